// ===== core/adc_gain_offset_output_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - Accept shaper codes up to 54
// - Gain 0 to 6 dB, half-dB steps
// - Gain disabled after reset until enabled
// - Mode bits enable gain, then gain code
// - Cancel DC offset up to 10 mV
// - Estimate and subtract offset every sample
// - Four-bit loop speed, codes above 11 reserved
// - Hold freezes estimate, keeps applying it
// - Offset cancel off after reset
// - Two 11-bit channels, one shared clock
// - One bit picks DDR LVDS or CMOS
// - DDR: two bits per pair per period
// - CMOS: one bit per pin per cycle
module adc_gain_offset_output_ctrl #(
    parameter int SAMPLE_W = agoc_pkg::SAMPLE_W
) (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                sampleClockPin,
    input  wire logic [SAMPLE_W-1:0] chanASample,
    input  wire logic [SAMPLE_W-1:0] chanBSample,
    input  wire logic                digitalModeOne,
    input  wire logic                digitalModeTwo,
    input  wire logic [3:0]          gainCode,
    input  wire logic                dc_cancel_enable,
    input  wire logic [3:0]          dc_cancel_loop_speed,
    input  wire logic                dc_cancel_hold,
    input  wire logic [5:0]          noise_shaper_select,
    input  wire logic                noise_shaper_pin_bypass,
    input  wire logic                lvdsMode,
    output logic      [5:0]          shaperCode,
    output logic                     shaperWide,
    output logic                     shaperActive,
    output logic      [5:0]          lvdsPairA,
    output logic      [5:0]          lvdsPairB,
    output logic      [SAMPLE_W-1:0] cmosDataA,
    output logic      [SAMPLE_W-1:0] cmosDataB,
    output logic                     forwarded_sample_clock
);
    // ------------------------------------------------------------------
    // Sampling clock pin synchroniser and edge detection
    // ------------------------------------------------------------------
    logic [agoc_pkg::PIN_SYNC_DEPTH-1:0] clkSync;
    logic                                clkLevel;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkSync <= '0;
        end else begin
            clkSync <= {clkSync[1:0], sampleClockPin};
        end
    end

    wire clkAgree  = clkSync[1] == clkSync[2];
    wire next_clkLevel = clkAgree ? clkSync[2] : clkLevel;
    wire clkRise   = next_clkLevel && !clkLevel;
    wire clkFall   = !next_clkLevel && clkLevel;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkLevel <= 1'b0;
        end else begin
            clkLevel <= next_clkLevel;
        end
    end

    // ------------------------------------------------------------------
    // Sample capture on the rising sampling clock edge
    // ------------------------------------------------------------------
    logic [SAMPLE_W-1:0] capA;
    logic [SAMPLE_W-1:0] capB;
    logic                capStrobe;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            capA      <= '0;
            capB      <= '0;
            capStrobe <= 1'b0;
        end else begin
            capStrobe <= clkRise;
            if (clkRise) begin
                capA <= chanASample;
                capB <= chanBSample;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------
    wire bothModes = digitalModeOne && digitalModeTwo;
    wire gainOn    = bothModes;
    wire cancelOn  = bothModes && dc_cancel_enable;

    // ------------------------------------------------------------------
    // Per-channel gain and offset paths
    // ------------------------------------------------------------------
    agoc_chan_if chanIf [2] ();
    wire [SAMPLE_W-1:0] capSel [2];
    wire [SAMPLE_W-1:0] chanOut [2];
    assign capSel[0] = capA;
    assign capSel[1] = capB;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            assign chanIf[ch].rawSample    = $signed(capSel[ch]);
            assign chanIf[ch].sampleStrobe = capStrobe;
            assign chanIf[ch].gainOn       = gainOn;
            assign chanIf[ch].gainCode     = gainCode;
            assign chanIf[ch].cancelOn     = cancelOn;
            assign chanIf[ch].cancelHold   = dc_cancel_hold;
            assign chanIf[ch].loopSpeed    = dc_cancel_loop_speed;
            assign chanOut[ch]             = chanIf[ch].outSample;

            agoc_channel u_chan (
                .ref_clk (ref_clk),
                .sys_rst (sys_rst),
                .bus     (chanIf[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Noise-shaper selection, taken when the pin bypass bit rises
    // ------------------------------------------------------------------
    logic bypassSeen;
    wire  shaperLoad = noise_shaper_pin_bypass && !bypassSeen && digitalModeTwo;
    wire  shaperOk   = noise_shaper_select <= agoc_pkg::SHAPER_MAX;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bypassSeen   <= 1'b0;
            shaperCode   <= agoc_pkg::SHAPER_RST;
            shaperWide   <= 1'b0;
            shaperActive <= 1'b0;
        end else begin
            bypassSeen <= noise_shaper_pin_bypass;
            if (!noise_shaper_pin_bypass) begin
                shaperActive <= 1'b0;
            end else if (shaperLoad && shaperOk) begin
                shaperCode   <= noise_shaper_select;
                shaperWide   <= noise_shaper_select >= agoc_pkg::SHAPER_WIDE_MIN;
                shaperActive <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output port: DDR pairs or parallel CMOS
    // ------------------------------------------------------------------
    // Pad to an even width so bit pairs map cleanly onto six lanes
    wire [2*agoc_pkg::PAIR_COUNT-1:0] padA = {{(2*agoc_pkg::PAIR_COUNT-SAMPLE_W){1'b0}}, chanOut[0]};
    wire [2*agoc_pkg::PAIR_COUNT-1:0] padB = {{(2*agoc_pkg::PAIR_COUNT-SAMPLE_W){1'b0}}, chanOut[1]};
    wire [5:0] evenA;
    wire [5:0] oddA;
    wire [5:0] evenB;
    wire [5:0] oddB;

    genvar p;
    generate
        for (p = 0; p < agoc_pkg::PAIR_COUNT; p++) begin : g_pair
            assign evenA[p] = padA[2*p];
            assign oddA[p]  = padA[2*p+1];
            assign evenB[p] = padB[2*p];
            assign oddB[p]  = padB[2*p+1];
        end
    endgenerate

    agoc_pkg::agoc_half_t half;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            half <= agoc_pkg::AGOC_HALF_LOW;
        end else if (clkRise) begin
            half <= agoc_pkg::AGOC_HALF_LOW;
        end else if (clkFall) begin
            half <= agoc_pkg::AGOC_HALF_HIGH;
        end
    end

    wire lowHalf = (half == agoc_pkg::AGOC_HALF_LOW);
    // CMOS outputs update two cycles after the sampling edge, once the sample has settled
    logic [1:0] edgePipe;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            edgePipe <= 2'b00;
        end else begin
            edgePipe <= {edgePipe[0], capStrobe};
        end
    end

    wire dataTick = edgePipe[0];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lvdsPairA              <= '0;
            lvdsPairB              <= '0;
            cmosDataA              <= '0;
            cmosDataB              <= '0;
            forwarded_sample_clock <= 1'b0;
        end else begin
            forwarded_sample_clock <= clkLevel;
            if (lvdsMode) begin
                lvdsPairA <= lowHalf ? evenA : oddA;
                lvdsPairB <= lowHalf ? evenB : oddB;
                cmosDataA <= '0;
                cmosDataB <= '0;
            end else begin
                lvdsPairA <= '0;
                lvdsPairB <= '0;
                if (dataTick) begin
                    cmosDataA <= chanOut[0];
                    cmosDataB <= chanOut[1];
                end
            end
        end
    end

endmodule : adc_gain_offset_output_ctrl

// ===== core/agoc_chan_if.sv
`timescale 1ns/1ns
interface agoc_chan_if;
    logic signed [10:0] rawSample;
    logic signed [10:0] outSample;
    logic               sampleStrobe;
    logic               gainOn;
    logic        [3:0]  gainCode;
    logic               cancelOn;
    logic               cancelHold;
    logic        [3:0]  loopSpeed;

    modport ctrl (output rawSample, sampleStrobe, gainOn, gainCode, cancelOn, cancelHold, loopSpeed,
                  input  outSample);
    modport chan (input  rawSample, sampleStrobe, gainOn, gainCode, cancelOn, cancelHold, loopSpeed,
                  output outSample);
endinterface : agoc_chan_if

// ===== core/agoc_channel.sv
`timescale 1ns/1ns
module agoc_channel (
    input  wire logic    ref_clk,
    input  wire logic    sys_rst,
    agoc_chan_if.chan    bus
);
    // ------------------------------------------------------------------
    // Offset estimate
    // ------------------------------------------------------------------
    logic signed [agoc_pkg::ACC_W-1:0] dcAcc;
    wire  signed [agoc_pkg::ACC_W-1:0] rawWide   = agoc_pkg::ACC_W'(bus.rawSample);
    wire  [5:0]                        shiftBy   = 6'(agoc_pkg::LOOP_BASE_SHIFT) + {2'b00, bus.loopSpeed};
    wire  signed [agoc_pkg::ACC_W-1:0] estWide   = dcAcc >>> shiftBy;
    wire  signed [agoc_pkg::ACC_W-1:0] limWide   = agoc_pkg::ACC_W'(agoc_pkg::DC_LIMIT);
    wire  signed [agoc_pkg::ACC_W-1:0] estClip   = (estWide > limWide) ? limWide :
                                                   (estWide < -limWide) ? -limWide : estWide;
    wire  signed [11:0]                estimate  = 12'(estClip);
    wire  signed [agoc_pkg::ACC_W-1:0] next_dcAcc = dcAcc + rawWide - estWide;
    wire                               speedOk   = bus.loopSpeed <= agoc_pkg::LOOP_SPEED_MAX;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dcAcc <= '0;
        end else if (!bus.cancelOn) begin
            dcAcc <= '0;
        end else if (bus.sampleStrobe && !bus.cancelHold && speedOk) begin
            dcAcc <= next_dcAcc;
        end
    end

    // ------------------------------------------------------------------
    // Subtraction, gain and saturation
    // ------------------------------------------------------------------
    wire signed [11:0] corrected = 12'(bus.rawSample) - (bus.cancelOn ? estimate : 12'sh000);
    wire        [3:0]  gainSel   = (bus.gainCode > agoc_pkg::GAIN_MAX) ? agoc_pkg::GAIN_MAX : bus.gainCode;
    wire        [3:0]  gainUse   = bus.gainOn ? gainSel : 4'h0;
    // Gain factor 10^(g/40) in Q12 for half-dB steps
    logic       [15:0] gainMul;
    always_comb begin
        case (gainUse)
            4'h0:    gainMul = 16'h1000;
            4'h1:    gainMul = 16'h10f3;
            4'h2:    gainMul = 16'h11f4;
            4'h3:    gainMul = 16'h1304;
            4'h4:    gainMul = 16'h1425;
            4'h5:    gainMul = 16'h1556;
            4'h6:    gainMul = 16'h169a;
            4'h7:    gainMul = 16'h17f1;
            4'h8:    gainMul = 16'h195c;
            4'h9:    gainMul = 16'h1adc;
            4'ha:    gainMul = 16'h1c74;
            4'hb:    gainMul = 16'h1e23;
            default: gainMul = 16'h1fed;
        endcase
    end
    wire signed [28:0] scaled  = 29'(corrected) * $signed({1'b0, gainMul});
    wire signed [16:0] scaledQ = 17'(scaled >>> 12);
    wire signed [10:0] clipped = (scaledQ > 17'sd1023) ? 11'sh3ff :
                                 (scaledQ < -17'sd1024) ? 11'sh400 : 11'(scaledQ);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus.outSample <= '0;
        end else if (bus.sampleStrobe) begin
            bus.outSample <= clipped;
        end
    end
endmodule : agoc_channel

// ===== core/agoc_pkg.sv
package agoc_pkg;

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    localparam int SAMPLE_W      = 11;
    localparam int PAIR_COUNT    = 6;
    localparam int GAIN_W        = 4;
    localparam int SHAPER_W      = 6;
    localparam int LOOP_SPEED_W  = 4;
    localparam int ACC_W         = 48;
    localparam int PIN_SYNC_DEPTH = 3;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] SHAPER_MAX      = 6'h36;
    localparam logic [5:0] SHAPER_WIDE_MIN = 6'h28;
    localparam logic [3:0] GAIN_MAX        = 4'hc;
    localparam logic [3:0] LOOP_SPEED_MAX  = 4'hb;
    localparam logic [3:0] LOOP_SPEED_RST  = 4'h0;
    localparam logic [3:0] GAIN_RST        = 4'h0;
    localparam logic [5:0] SHAPER_RST      = 6'h00;
    // Base shift: time constant of 1M (2^20) samples at code 0
    localparam int LOOP_BASE_SHIFT = 20;
    // Offset window: 10 mV of a 2 V full scale over 2048 codes, about 10.2 codes, rounded up to 11
    localparam logic [10:0] DC_LIMIT = 11'h00b;

    typedef enum logic [1:0] {
        AGOC_HALF_LOW  = 2'b01,
        AGOC_HALF_HIGH = 2'b10
    } agoc_half_t;

endpackage : agoc_pkg

// ===== tb/agoc_checker.sv
`timescale 1ns/1ns
module agoc_checker #(
    parameter int SAMPLE_W = 11
) (
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    input wire logic                sampleClockPin,
    input wire logic [SAMPLE_W-1:0] chanASample,
    input wire logic [SAMPLE_W-1:0] chanBSample,
    input wire logic                digitalModeOne,
    input wire logic                digitalModeTwo,
    input wire logic                lvdsMode,
    input wire logic [5:0]          shaperCode,
    input wire logic                shaperWide,
    input wire logic [5:0]          lvdsPairA,
    input wire logic [5:0]          lvdsPairB,
    input wire logic [SAMPLE_W-1:0] cmosDataA,
    input wire logic [SAMPLE_W-1:0] cmosDataB,
    input wire logic                forwarded_sample_clock
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    shaper_range_a: assert property (shaperCode <= 6'h36)
        else $error("shaper code above limit");
    shaper_wide_a: assert property (shaperWide == (shaperCode >= 6'h28))
        else $error("wide flag wrong");
    shaper_mode_a: assert property ($changed(shaperCode) |-> $past(digitalModeTwo) || $past(digitalModeTwo, 2))
        else $error("shaper code changed outside sequence");
    cmos_quiet_a: assert property (lvdsMode && $past(lvdsMode) && $past(lvdsMode, 2) |-> cmosDataA == '0 && cmosDataB == '0)
        else $error("parallel bus active in pair mode");
    lane_quiet_a: assert property (!lvdsMode [*3] |-> lvdsPairA == 6'h00 && lvdsPairB == 6'h00)
        else $error("pairs active in parallel mode");
    fwd_clock_a: assert property ($rose(forwarded_sample_clock) |-> $past(sampleClockPin, 2) && $past(sampleClockPin, 3))
        else $error("output clock not aligned");
    lane_pad_a: assert property (lvdsMode && $past(lvdsMode, 3) && !forwarded_sample_clock
        && !$past(forwarded_sample_clock, 2) |-> !lvdsPairA[5] && !lvdsPairB[5])
        else $error("pad bit not zero");
    pass_thru_a: assert property ($changed(cmosDataA) && !lvdsMode && !$past(lvdsMode, 2) && !(digitalModeOne && digitalModeTwo)
        && !($past(digitalModeOne, 4) && $past(digitalModeTwo, 4)) |-> cmosDataA == $past(chanASample, 3))
        else $error("channel A altered while gain is off");
    pass_thru_b_a: assert property ($changed(cmosDataB) && !lvdsMode && !$past(lvdsMode, 2) && !(digitalModeOne && digitalModeTwo)
        && !($past(digitalModeOne, 4) && $past(digitalModeTwo, 4)) |-> cmosDataB == $past(chanBSample, 3))
        else $error("channel B altered while correction is off");
endmodule : agoc_checker

bind adc_gain_offset_output_ctrl agoc_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sampleClockPin(sampleClockPin), .chanASample(chanASample), .chanBSample(chanBSample),
    .digitalModeOne(digitalModeOne), .digitalModeTwo(digitalModeTwo), .lvdsMode(lvdsMode), .shaperCode(shaperCode),
    .shaperWide(shaperWide), .lvdsPairA(lvdsPairA), .lvdsPairB(lvdsPairB), .cmosDataA(cmosDataA),
    .cmosDataB(cmosDataB), .forwarded_sample_clock(forwarded_sample_clock));

// ===== tb/agoc_rx_model.sv
`timescale 1ns/1ns
module agoc_rx_model (
    input  wire logic        ref_clk,
    input  wire logic        fwdClk,
    input  wire logic [5:0]  pairA,
    input  wire logic [5:0]  pairB,
    input  wire logic [10:0] cmosA,
    input  wire logic [10:0] cmosB,
    output logic      [10:0] lvdsWordA,
    output logic      [10:0] lvdsWordB,
    output logic      [10:0] cmosWordA,
    output logic      [10:0] cmosWordB
);
    logic [1:0] fwdHist;
    logic [5:0] evenA;
    logic [5:0] evenB;
    logic [5:0] oddA;
    logic [5:0] oddB;

    always @(posedge ref_clk) begin
        fwdHist <= {fwdHist[0], fwdClk};
        if (fwdClk && fwdHist == 2'b01) begin
            evenA <= pairA;
            evenB <= pairB;
        end
        if (!fwdClk && fwdHist == 2'b10) begin
            oddA <= pairA;
            oddB <= pairB;
        end
        if (fwdClk && !fwdHist[0]) begin
            cmosWordA <= cmosA;
            cmosWordB <= cmosB;
            for (int p = 0; p < 6; p++) begin
                lvdsWordA[2*p] <= evenA[p];
                lvdsWordB[2*p] <= evenB[p];
                if (p < 5) begin
                    lvdsWordA[2*p+1] <= oddA[p];
                    lvdsWordB[2*p+1] <= oddB[p];
                end
            end
        end
    end
endmodule : agoc_rx_model

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic        ref_clk, sys_rst, sampleClockPin, digitalModeOne, digitalModeTwo, lvdsMode;
    logic        dc_cancel_enable, dc_cancel_hold, noise_shaper_pin_bypass, shaperWide, forwarded_sample_clock;
    logic        shaperActive;
    logic [10:0] chanASample, chanBSample, cmosDataA, cmosDataB;
    logic [10:0] lvdsWordA, lvdsWordB, cmosWordA, cmosWordB;
    logic [5:0]  noise_shaper_select, shaperCode, lvdsPairA, lvdsPairB;
    logic [3:0]  gainCode, dc_cancel_loop_speed;
    logic [2:0]  pinCnt;
    int          error_cnt;
    int          check_count;

    adc_gain_offset_output_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .sampleClockPin(sampleClockPin),
        .chanASample(chanASample), .chanBSample(chanBSample), .digitalModeOne(digitalModeOne),
        .digitalModeTwo(digitalModeTwo), .gainCode(gainCode), .dc_cancel_enable(dc_cancel_enable),
        .dc_cancel_loop_speed(dc_cancel_loop_speed), .dc_cancel_hold(dc_cancel_hold),
        .noise_shaper_select(noise_shaper_select), .noise_shaper_pin_bypass(noise_shaper_pin_bypass),
        .lvdsMode(lvdsMode), .shaperCode(shaperCode), .shaperWide(shaperWide), .shaperActive(shaperActive),
        .lvdsPairA(lvdsPairA), .lvdsPairB(lvdsPairB), .cmosDataA(cmosDataA), .cmosDataB(cmosDataB),
        .forwarded_sample_clock(forwarded_sample_clock));
    agoc_rx_model u_rx (.ref_clk(ref_clk), .fwdClk(forwarded_sample_clock), .pairA(lvdsPairA), .pairB(lvdsPairB),
        .cmosA(cmosDataA), .cmosB(cmosDataB), .lvdsWordA(lvdsWordA), .lvdsWordB(lvdsWordB),
        .cmosWordA(cmosWordA), .cmosWordB(cmosWordB));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Sampling clock of 400 ns, unrelated to the sample data changes
    always @(posedge ref_clk) begin
        pinCnt <= pinCnt + 3'h1;
        sampleClockPin <= ~pinCnt[2];
    end

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic wait_fwd(input int n);
        int t;
        repeat (n) begin
            t = 0;
            while (forwarded_sample_clock !== 1'b0 && t < 20) begin @(posedge ref_clk); t++; end
            while (forwarded_sample_clock !== 1'b1 && t < 40) begin @(posedge ref_clk); t++; end
            if (t >= 40) begin
                error_cnt++;
                $display("ERROR at %0t: output clock stuck", $time);
                end_of_test();
            end
        end
        #1;
    endtask : wait_fwd

    task automatic set_mode(input logic one, input logic two, input logic [3:0] gain);
        @(posedge ref_clk);
        digitalModeOne <= one;
        digitalModeTwo <= two;
        gainCode <= gain;
        wait_fwd(3);
    endtask : set_mode

    task automatic t_gain();
        check(cmosDataA, 11'h123);
        check(cmosDataB, 11'h5a5);
        check(cmosWordA, 11'h123);
        @(posedge ref_clk);
        chanASample <= 11'h064;
        set_mode(1'b1, 1'b1, 4'h0);
        check(cmosDataA, 11'h064);
        set_mode(1'b1, 1'b1, 4'h1);
        check({10'h000, cmosDataA === 11'h069 || cmosDataA === 11'h06a}, 11'h001);
        set_mode(1'b1, 1'b1, 4'hc);
        check({10'h000, cmosDataA === 11'h0c7 || cmosDataA === 11'h0c8}, 11'h001);
        set_mode(1'b1, 1'b1, 4'hf);
        check({10'h000, cmosDataA === 11'h0c7 || cmosDataA === 11'h0c8}, 11'h001);
    endtask : t_gain

    task automatic t_cancel();
        set_mode(1'b1, 1'b1, 4'h0);
        @(posedge ref_clk);
        dc_cancel_enable <= 1'b1;
        dc_cancel_loop_speed <= 4'h0;
        wait_fwd(3);
        check(cmosDataA, 11'h064);
        @(posedge ref_clk);
        dc_cancel_hold <= 1'b1;
        wait_fwd(3);
        check(cmosDataA, 11'h064);
        @(posedge ref_clk);
        dc_cancel_loop_speed <= 4'hf;
        wait_fwd(3);
        check(cmosDataA, 11'h064);
        @(posedge ref_clk);
        dc_cancel_enable <= 1'b0;
        set_mode(1'b0, 1'b0, 4'h0);
    endtask : t_cancel

    task automatic shaper_load(input logic [5:0] code, input logic [5:0] expCode);
        @(posedge ref_clk);
        noise_shaper_pin_bypass <= 1'b0;
        digitalModeTwo <= 1'b0;
        @(posedge ref_clk);
        noise_shaper_select <= code;
        @(posedge ref_clk);
        digitalModeTwo <= 1'b1;
        @(posedge ref_clk);
        noise_shaper_pin_bypass <= 1'b1;
        wait_fwd(1);
        check({5'h00, shaperCode}, {5'h00, expCode});
        check({10'h000, shaperWide}, {10'h000, expCode >= 6'h28});
        check({10'h000, shaperActive}, {10'h000, code <= 6'h36});
    endtask : shaper_load

    task automatic t_lvds();
        @(posedge ref_clk);
        lvdsMode <= 1'b1;
        chanASample <= 11'h2b6;
        chanBSample <= 11'h54d;
        wait_fwd(4);
        check(cmosDataA, 11'h000);
        check(lvdsWordA, 11'h2b6);
        check(lvdsWordB, 11'h54d);
        @(posedge ref_clk);
        lvdsMode <= 1'b0;
        wait_fwd(3);
        check(cmosDataA, 11'h2b6);
    endtask : t_lvds

    initial begin
        error_cnt = 0;
        check_count = 0;
        pinCnt = 3'h0;
        sampleClockPin = 1'b0;
        sys_rst = 1'b1;
        {digitalModeOne, digitalModeTwo, lvdsMode, dc_cancel_hold, noise_shaper_pin_bypass} = 5'h00;
        chanASample = 11'h123;
        chanBSample = 11'h5a5;
        gainCode = 4'hc;
        dc_cancel_enable = 1'b0;
        dc_cancel_loop_speed = 4'h0;
        noise_shaper_select = 6'h00;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_fwd(3);
        t_gain();
        t_cancel();
        shaper_load(6'h36, 6'h36);
        shaper_load(6'h37, 6'h36);
        shaper_load(6'h27, 6'h27);
        t_lvds();
        end_of_test();
    end
endmodule : tb_top
